// ### tcc_pkg.sv
package tcc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CTRL_C = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_MATCH_A = 8'h10;
  localparam logic [7:0] OFS_MATCH_B = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
  localparam logic [7:0] OFS_PORT = 8'h20;
  // field positions
  localparam int CA_COM_A_LSB = 6;
  localparam int CA_COM_B_LSB = 4;
  localparam int CA_WM_LSB = 0;
  localparam int CB_WM_HIGH_BIT = 3;
  localparam int CB_CS_LSB = 0;
  localparam int CC_FORCE_A_BIT = 7;
  localparam int CC_FORCE_B_BIT = 6;
  localparam int FLG_OVF = 0;
  localparam int FLG_A = 1;
  localparam int FLG_B = 2;
  localparam int PORT_LATCH_LSB = 0;
  localparam int PORT_DIR_LSB = 2;
  // waveform modes
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PC_MAX = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_MAX = 3'h3;
  localparam logic [2:0] WM_PC_A = 3'h5;
  localparam logic [2:0] WM_FAST_A = 3'h7;
  // output action codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // tick sources
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_W = 10;
  localparam logic [PRE_W-1:0] PRE_MASK_8 = 10'h007;
  localparam logic [PRE_W-1:0] PRE_MASK_64 = 10'h03F;
  localparam logic [PRE_W-1:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [PRE_W-1:0] PRE_MASK_1024 = 10'h3FF;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] addr;
  } tcc_bus_req_t;

  typedef enum logic [1:0] {
    TCC_UP = 2'b01,
    TCC_DOWN = 2'b10
  } tcc_dir_t;
endpackage

// ### tcc_top.sv
module tcc_top
  import tcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_tick_in,
  input wire logic irq_ack_ovf,
  input wire logic irq_ack_a,
  input wire logic irq_ack_b,
  output logic irq_ovf,
  output logic irq_a,
  output logic irq_b,
  output logic wave_pin_a_out,
  output logic wave_pin_a_oe,
  output logic wave_pin_b_out,
  output logic wave_pin_b_oe
);
  tcc_bus_req_t dreq_reg;
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [3:0] port_reg;
  logic [2:0] irq_en_reg;
  logic [2:0] flag_reg;
  logic [7:0] count_value;
  logic block_reg;
  tcc_dir_t dir_reg;
  logic [PRE_W-1:0] pre_reg;
  logic ext_prev_reg;
  logic [7:0] match_act [2];
  logic [7:0] match_buf [2];
  logic [1:0] wave_output_state;
  logic [1:0] pin_out_reg;
  logic [1:0] pin_oe_reg;
  logic we_ctrl_a, we_ctrl_b, we_ctrl_c, we_count, we_flags, we_en, we_port;
  logic [1:0] we_match;
  logic [2:0] wave_mode_field;
  logic [2:0] tick_source_select;
  logic [1:0] output_action_field [2];
  logic [1:0] force_match_strobe;
  logic timer_tick, is_fast, is_pc, is_pwm, at_top, ovf_ev, wrap_ev, upd_ev;
  logic [7:0] top_val, cnt_step;
  tcc_dir_t dir_next;
  logic [1:0] match_hit;
  logic [31:0] rdata_next;
  logic [2:0] flag_set, flag_clr;

  assign wave_mode_field = {ctrl_b_reg[CB_WM_HIGH_BIT], ctrl_a_reg[CA_WM_LSB +: 2]};
  assign tick_source_select = ctrl_b_reg[CB_CS_LSB +: 3];
  assign output_action_field[0] = ctrl_a_reg[CA_COM_A_LSB +: 2];
  assign output_action_field[1] = ctrl_a_reg[CA_COM_B_LSB +: 2];
  assign force_match_strobe = {hwdata[CC_FORCE_B_BIT], hwdata[CC_FORCE_A_BIT]} & {2{we_ctrl_c}};

  // ahb-lite slave: zero wait states, always OKAY
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      dreq_reg <= '0;
    else if (hready)
      dreq_reg <= '{valid: hsel & htrans[1], wr: hwrite, addr: haddr[7:0]};
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  always_comb
  begin
    we_ctrl_a = 1'b0;
    we_ctrl_b = 1'b0;
    we_ctrl_c = 1'b0;
    we_count = 1'b0;
    we_flags = 1'b0;
    we_en = 1'b0;
    we_port = 1'b0;
    we_match = 2'b00;
    if (dreq_reg.valid && dreq_reg.wr)
    begin
      if (dreq_reg.addr == OFS_CTRL_A)
        we_ctrl_a = 1'b1;
      else if (dreq_reg.addr == OFS_CTRL_B)
        we_ctrl_b = 1'b1;
      else if (dreq_reg.addr == OFS_CTRL_C)
        we_ctrl_c = 1'b1;
      else if (dreq_reg.addr == OFS_COUNT)
        we_count = 1'b1;
      else if (dreq_reg.addr == OFS_MATCH_A)
        we_match[0] = 1'b1;
      else if (dreq_reg.addr == OFS_MATCH_B)
        we_match[1] = 1'b1;
      else if (dreq_reg.addr == OFS_FLAGS)
        we_flags = 1'b1;
      else if (dreq_reg.addr == OFS_IRQ_EN)
        we_en = 1'b1;
      else if (dreq_reg.addr == OFS_PORT)
        we_port = 1'b1;
    end
  end

  // read data is captured in the address phase; unmapped reads give zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (haddr[7:0] == OFS_CTRL_A)
      rdata_next[7:0] = ctrl_a_reg;
    else if (haddr[7:0] == OFS_CTRL_B)
      rdata_next[7:0] = ctrl_b_reg;
    else if (haddr[7:0] == OFS_COUNT)
      rdata_next[7:0] = count_value;
    else if (haddr[7:0] == OFS_MATCH_A)
      rdata_next[7:0] = match_buf[0];
    else if (haddr[7:0] == OFS_MATCH_B)
      rdata_next[7:0] = match_buf[1];
    else if (haddr[7:0] == OFS_FLAGS)
      rdata_next[2:0] = flag_reg;
    else if (haddr[7:0] == OFS_IRQ_EN)
      rdata_next[2:0] = irq_en_reg;
    else if (haddr[7:0] == OFS_PORT)
      rdata_next[3:0] = port_reg;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
      hrdata <= rdata_next;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_a_reg <= 8'h00;
      ctrl_b_reg <= 8'h00;
      irq_en_reg <= 3'h0;
      port_reg <= 4'h0;
    end
    else
    begin
      if (we_ctrl_a)
        ctrl_a_reg <= hwdata[7:0];
      if (we_ctrl_b)
        ctrl_b_reg <= hwdata[7:0] & 8'h0F;
      if (we_en)
        irq_en_reg <= hwdata[2:0];
      if (we_port)
        port_reg <= hwdata[3:0];
    end
  end

  // tick source: prescaler taps or edge of the external input
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_reg <= '0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_reg + 10'h001;
      ext_prev_reg <= ext_tick_in;
    end
  end

  always_comb
  begin
    case (tick_source_select)
      CS_DIV1: timer_tick = 1'b1;
      CS_DIV8: timer_tick = (pre_reg & PRE_MASK_8) == PRE_MASK_8;
      CS_DIV64: timer_tick = (pre_reg & PRE_MASK_64) == PRE_MASK_64;
      CS_DIV256: timer_tick = (pre_reg & PRE_MASK_256) == PRE_MASK_256;
      CS_DIV1024: timer_tick = (pre_reg & PRE_MASK_1024) == PRE_MASK_1024;
      CS_EXT_FALL: timer_tick = ext_prev_reg & ~ext_tick_in;
      CS_EXT_RISE: timer_tick = ~ext_prev_reg & ext_tick_in;
      default: timer_tick = 1'b0;
    endcase
  end

  // counting sequence depends on the mode field and, in WM_CTC, WM_PC_A and WM_FAST_A, on match_act[0]
  always_comb
  begin
    is_fast = (wave_mode_field == WM_FAST_MAX) || (wave_mode_field == WM_FAST_A);
    is_pc = (wave_mode_field == WM_PC_MAX) || (wave_mode_field == WM_PC_A);
    is_pwm = is_fast | is_pc;
    top_val = CNT_MAX;
    if ((wave_mode_field == WM_FAST_A) || (wave_mode_field == WM_PC_A)
        || (wave_mode_field == WM_CTC))
      top_val = match_act[0];
    at_top = count_value == top_val;
    cnt_step = count_value + 8'h01;
    dir_next = TCC_UP;
    ovf_ev = 1'b0;
    wrap_ev = 1'b0;
    if (is_pc)
    begin
      dir_next = dir_reg;
      if (dir_reg == TCC_UP && at_top)
      begin
        dir_next = TCC_DOWN;
        cnt_step = count_value - 8'h01;
      end
      else if (dir_reg == TCC_DOWN && count_value == CNT_BOTTOM)
      begin
        dir_next = TCC_UP;
        ovf_ev = 1'b1;
      end
      else if (dir_reg == TCC_DOWN)
        cnt_step = count_value - 8'h01;
    end
    else if ((is_fast || wave_mode_field == WM_CTC) && at_top)
    begin
      cnt_step = CNT_BOTTOM;
      wrap_ev = 1'b1;
      ovf_ev = is_fast || (count_value == CNT_MAX);
    end
    else
    begin
      ovf_ev = count_value == CNT_MAX;
      wrap_ev = ovf_ev;
    end
    upd_ev = is_fast ? wrap_ev : (is_pc && dir_reg == TCC_UP && at_top);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_value <= CNT_BOTTOM;
      dir_reg <= TCC_UP;
    end
    else if (we_count)
      count_value <= hwdata[7:0];
    else if (timer_tick)
    begin
      count_value <= cnt_step;
      dir_reg <= dir_next;
    end
  end

  // a count write masks compares until the next tick, running or not
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      block_reg <= 1'b0;
    else if (we_count)
      block_reg <= 1'b1;
    else if (timer_tick)
      block_reg <= 1'b0;
  end

  // set wins over clear so a coincident event is never lost
  assign flag_set = {timer_tick & match_hit[1], timer_tick & match_hit[0], timer_tick & ovf_ev};
  assign flag_clr = ({3{we_flags}} & hwdata[2:0]) | {irq_ack_b, irq_ack_a, irq_ack_ovf};

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      flag_reg <= 3'h0;
    else
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_ovf <= 1'b0;
      irq_a <= 1'b0;
      irq_b <= 1'b0;
    end
    else
    begin
      irq_ovf <= flag_reg[FLG_OVF] & irq_en_reg[FLG_OVF];
      irq_a <= flag_reg[FLG_A] & irq_en_reg[FLG_A];
      irq_b <= flag_reg[FLG_B] & irq_en_reg[FLG_B];
    end
  end

  // next output state for a match; pwm codes pick polarity by slope
  function automatic logic oc_apply(input logic cur, input logic [1:0] com,
                                    input logic pwm, input logic down, input logic tog_ok);
    logic res;
    res = cur;
    case (com)
      COM_TOGGLE: res = (!pwm || tog_ok) ? ~cur : cur;
      COM_CLEAR: res = pwm ? down : 1'b0;
      COM_SET: res = pwm ? ~down : 1'b1;
      default: res = cur;
    endcase
    return res;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_unit
      assign match_hit[gi] = (count_value == match_act[gi]) && !block_reg;

      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          match_buf[gi] <= 8'h00;
          match_act[gi] <= 8'h00;
        end
        else
        begin
          if (we_match[gi])
            match_buf[gi] <= hwdata[7:0];
          if (we_match[gi] && !is_pwm)
            match_act[gi] <= hwdata[7:0];
          else if (timer_tick && upd_ev)
            match_act[gi] <= match_buf[gi];
        end
      end

      // mode changes never touch this state; fast pwm bottom wins over a match in the same tick
      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
          wave_output_state[gi] <= 1'b0;
        else if (force_match_strobe[gi] && !is_pwm)
          wave_output_state[gi] <= oc_apply(wave_output_state[gi],
                                            output_action_field[gi], 1'b0, 1'b0, 1'b0);
        else if (timer_tick && is_fast && wrap_ev
                 && output_action_field[gi][1])
          wave_output_state[gi] <= output_action_field[gi] == COM_CLEAR;
        else if (timer_tick && match_hit[gi])
          wave_output_state[gi] <= oc_apply(wave_output_state[gi], output_action_field[gi],
                                            is_pwm, dir_reg == TCC_DOWN,
                                            gi == 0 && ctrl_b_reg[CB_WM_HIGH_BIT] && is_fast);
      end

      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          pin_out_reg[gi] <= 1'b0;
          pin_oe_reg[gi] <= 1'b0;
        end
        else
        begin
          pin_out_reg[gi] <= (|output_action_field[gi]) ? wave_output_state[gi]
                                                        : port_reg[PORT_LATCH_LSB + gi];
          pin_oe_reg[gi] <= port_reg[PORT_DIR_LSB + gi];
        end
      end
    end
  endgenerate

  assign wave_pin_a_out = pin_out_reg[0];
  assign wave_pin_b_out = pin_out_reg[1];
  assign wave_pin_a_oe = pin_oe_reg[0];
  assign wave_pin_b_oe = pin_oe_reg[1];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  stop_no_count_a: assert property ((tick_source_select == CS_STOP && !we_count)
    |=> count_value == $past(count_value)) else $error("count moved while stopped");
  write_wins_a: assert property (we_count
    |=> count_value == $past(hwdata[7:0])) else $error("count write lost");
  normal_step_a: assert property ((timer_tick && !we_count && wave_mode_field == WM_NORMAL)
    |=> count_value == $past(count_value) + 8'h01) else $error("normal step wrong");
  ovf_wrap_a: assert property ((timer_tick && !we_count && wave_mode_field == WM_NORMAL
    && count_value == CNT_MAX) |=> flag_reg[FLG_OVF] && count_value == CNT_BOTTOM)
    else $error("overflow not flagged at wrap");
  ctc_clear_a: assert property ((timer_tick && !we_count && wave_mode_field == WM_CTC
    && count_value == match_act[0]) |=> count_value == CNT_BOTTOM) else $error("no clear");
  match_flag_a: assert property ((timer_tick && count_value == match_act[0] && !block_reg)
    |=> flag_reg[FLG_A]) else $error("match flag a not set");
  block_match_a: assert property ((block_reg && !flag_reg[FLG_A])
    |=> !flag_reg[FLG_A]) else $error("blocked match set flag");
  force_flag_a: assert property ((force_match_strobe[0] && !timer_tick && !flag_reg[FLG_A])
    |=> !flag_reg[FLG_A] && count_value == $past(count_value)) else $error("force side effect");
  buf_hold_a: assert property ((is_pwm && !(timer_tick && upd_ev))
    |=> match_act[0] == $past(match_act[0])) else $error("buffer leaked early");
  pin_override_a: assert property ((output_action_field[0] != COM_OFF)
    |=> wave_pin_a_out == $past(wave_output_state[0])) else $error("pin not overridden");
endmodule

// ### tcc_host_model.sv
module tcc_host_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ext_run,
  input wire logic [2:0] irq,
  output logic [2:0] ack,
  output logic ext_tick_in,
  output logic [7:0] ack_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_reg;
  logic [1:0] ext_div_reg;
  // one request serviced at a time; hold off until the flag has had time to drop
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack <= 3'h0;
      hold_reg <= 2'h0;
      ack_cnt <= 8'h00;
    end
    else if (hold_reg != 2'h0)
    begin
      ack <= 3'h0;
      hold_reg <= hold_reg - 2'h1;
    end
    else if (irq != 3'h0)
    begin
      ack <= irq & (~irq + 3'h1);
      hold_reg <= 2'h3;
      ack_cnt <= ack_cnt + 8'h01;
    end
  end
  // external tick source, one edge of each kind every 8 cycles, still when idle
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_div_reg <= 2'h0;
      ext_tick_in <= 1'b0;
    end
    else if (ext_run)
    begin
      ext_div_reg <= ext_div_reg + 2'h1;
      if (ext_div_reg == 2'h3)
        ext_tick_in <= ~ext_tick_in;
    end
  end
endmodule

// ### tb.sv
module tb
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, hsel, hwrite, hready, ext_run, st;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  wire [2:0] irq;
  logic [2:0] ack, m;
  logic hreadyout, hresp, ext_tick_in, pa, pao, pb, pbo;
  logic [7:0] ack_cnt;
  int n_fail, num_checks;
  integer seed;
  logic [1:0] acts [7] = '{COM_TOGGLE, COM_TOGGLE, COM_SET, COM_SET, COM_CLEAR, COM_OFF, COM_TOGGLE};
  logic [2:0] tops [3] = '{WM_CTC, WM_PC_A, WM_FAST_A};
  assign hready = hreadyout;

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  tcc_top i_tcc_top (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_tick_in(ext_tick_in),
    .irq_ack_ovf(ack[0]), .irq_ack_a(ack[1]), .irq_ack_b(ack[2]), .irq_ovf(irq[0]),
    .irq_a(irq[1]), .irq_b(irq[2]), .wave_pin_a_out(pa), .wave_pin_a_oe(pao),
    .wave_pin_b_out(pb), .wave_pin_b_oe(pbo));

  tcc_host_model i_tcc_host_model (.core_clk(core_clk), .rstn(rstn), .ext_run(ext_run),
    .irq(irq), .ack(ack), .ext_tick_in(ext_tick_in), .ack_cnt(ack_cnt));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // single word transfer; holds each phase until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge core_clk);
    while (hready !== 1'b1)
      @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1)
      @(posedge core_clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic setup(input logic [2:0] md, input logic [1:0] aa, input logic [1:0] ab);
    wr(OFS_CTRL_A, {24'h0, aa, ab, 2'h0, md[1:0]});
    wr(OFS_CTRL_B, {28'h0, md[2], CS_STOP});
  endtask

  task automatic run(input int n, input logic [2:0] cs, input logic [2:0] md);
    wr(OFS_CTRL_B, {28'h0, md[2], cs});
    repeat (n) @(posedge core_clk);
    wr(OFS_CTRL_B, {28'h0, md[2], CS_STOP});
  endtask

  function automatic logic nxt(input logic [1:0] a, input logic s);
    case (a)
      COM_TOGGLE: return ~s;
      COM_SET: return 1'b1;
      COM_CLEAR: return 1'b0;
      default: return s;
    endcase
  endfunction

  function automatic int tdiv(input int c);
    case (c)
      1: return 1;
      2: return 8;
      3: return 64;
      4: return 256;
      5: return 1024;
      default: return 8;
    endcase
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // whole run is about 30k cycles; a hang is cut off after 50k
  initial
  begin
    #250us;
    n_fail++;
    test_done();
  end

  initial
  begin
    seed = 32'he9a6ecb8;
    n_fail = 0;
    num_checks = 0;
    st = 1'b0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ext_run = 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rdc(8'h40, 32'h0);
    rdc(OFS_CTRL_C, 32'h0);
    chk({30'h0, hreadyout, hresp}, {30'h0, 1'b1, HRESP_OKAY});
    // pins: latches high, both driven, so the source is visible
    wr(OFS_PORT, 32'hF);
    for (int k = 0; k < 7; k++)
    begin
      setup(WM_NORMAL, acts[k], acts[k]);
      wr(OFS_CTRL_C, 32'hC0);
      repeat (2) @(posedge core_clk);
      st = nxt(acts[k], st);
      chk({28'h0, pa, pao, pb, pbo}, {28'h0, {2{(acts[k] != COM_OFF) ? st : 1'b1, 1'b1}}});
    end
    rdc(OFS_FLAGS, 32'h0);
    setup(WM_FAST_MAX, COM_CLEAR, COM_CLEAR);
    wr(OFS_CTRL_C, 32'hC0);
    repeat (2) @(posedge core_clk);
    chk({30'h0, pa, pb}, {30'h0, st, st});
    setup(WM_NORMAL, COM_OFF, COM_OFF);
    for (int i = 0; i < 4; i++)
    begin
      m = 3'($random(seed));
      wr(OFS_COUNT, {24'h0, m, 5'($random(seed))});
      repeat (8) @(posedge core_clk);
      rdc(OFS_COUNT, {24'h0, m, hwdata[4:0]});
      wr(OFS_MATCH_B, {24'h0, ~hwdata[7:0]});
      rdc(OFS_MATCH_B, {24'h0, hwdata[7:0]});
    end
    ext_run <= 1'b1;
    for (int c = 1; c < 8; c++)
    begin
      wr(OFS_COUNT, 32'h0);
      run(tdiv(c) * 20, 3'(c), WM_NORMAL);
      bus(1'b0, OFS_COUNT, 32'h0);
      chk(32'(rd inside {[32'h13:32'h17]}), 32'h1);
    end
    ext_run <= 1'b0;
    wr(OFS_MATCH_A, 32'hF8);
    wr(OFS_MATCH_B, 32'h04);
    wr(OFS_COUNT, 32'hF0);
    wr(OFS_FLAGS, 32'h7);
    run(40, CS_DIV1, WM_NORMAL);
    rdc(OFS_FLAGS, 32'h7);
    wr(OFS_IRQ_EN, 32'h2);
    repeat (8) @(posedge core_clk);
    rdc(OFS_FLAGS, 32'h5);
    chk({24'h0, ack_cnt}, 32'h1);
    wr(OFS_IRQ_EN, 32'h0);
    wr(OFS_FLAGS, 32'h5);
    rdc(OFS_FLAGS, 32'h0);
    wr(OFS_MATCH_A, 32'h21);
    for (int k = 0; k < 2; k++)
    begin
      // first pass writes the count equal to the match value on purpose
      wr(OFS_COUNT, 32'h21 - 32'(k));
      wr(OFS_FLAGS, 32'h7);
      run(6, CS_DIV1, WM_NORMAL);
      bus(1'b0, OFS_FLAGS, 32'h0);
      chk({31'h0, rd[FLG_A]}, 32'(k));
    end
    for (int k = 0; k < 2; k++)
    begin
      m = k ? WM_FAST_MAX : WM_NORMAL;
      setup(WM_NORMAL, COM_OFF, COM_OFF);
      wr(OFS_MATCH_A, 32'h80);
      setup(m, COM_OFF, COM_OFF);
      wr(OFS_MATCH_A, 32'h30);
      wr(OFS_COUNT, 32'h10);
      wr(OFS_FLAGS, 32'h7);
      run(40, CS_DIV1, m);
      bus(1'b0, OFS_FLAGS, 32'h0);
      chk({31'h0, rd[FLG_A]}, 32'(1 - k));
    end
    setup(WM_NORMAL, COM_OFF, COM_OFF);
    wr(OFS_MATCH_A, 32'h08);
    for (int k = 0; k < 3; k++)
    begin
      m = tops[k];
      setup(m, 2'($random(seed)), 2'($random(seed)));
      wr(OFS_COUNT, 32'h02);
      wr(OFS_FLAGS, 32'h7);
      run(40, CS_DIV1, m);
      bus(1'b0, OFS_COUNT, 32'h0);
      chk(32'(rd <= 32'h08), 32'h1);
      bus(1'b0, OFS_FLAGS, 32'h0);
      chk({31'h0, rd[FLG_OVF]}, 32'(m != WM_CTC));
    end
    // phase correct to max: 15 ticks up to the top, then 27 ticks down
    setup(WM_PC_MAX, COM_OFF, COM_OFF);
    wr(OFS_COUNT, 32'hF0);
    wr(OFS_FLAGS, 32'h7);
    run(40, CS_DIV1, WM_PC_MAX);
    rdc(OFS_COUNT, 32'hE4);
    rdc(OFS_FLAGS, 32'h0);
    test_done();
  end
endmodule
